// [hdl/ptb_pkg.sv]
// shared constants of the pwm time base register block
package ptb_pkg;
	// datapath widths
	localparam int PTB_CNT_W    = 15;                 // time base count and period width
	localparam int PTB_ADDR_W   = 5;                  // avalon byte address width
	localparam int PTB_DATA_W   = 32;                 // avalon data width
	localparam int PTB_BE_W     = PTB_DATA_W / 8;     // byte enables
	localparam int PTB_INT_W    = 2;                  // number of interrupt sources

	// register byte offsets
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_COUNT   = 5'h00; // time_base_count
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_PERIOD  = 5'h04; // time_base_period
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_COMPARE = 5'h08; // special_event_compare
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_CONTROL = 5'h0C; // run and count mode
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_STATUS  = 5'h10; // sticky events, read clears
	localparam logic [PTB_ADDR_W-1:0] PTB_OFS_MASK    = 5'h14; // interrupt mask

	// field positions
	localparam int PTB_DIR_BIT      = 15; // direction flag in count register
	localparam int PTB_SEL_BIT      = 15; // trigger direction select in compare register
	localparam int PTB_CTRL_RUN_BIT = 0;  // time base runs
	localparam int PTB_CTRL_UPDN_BIT = 1; // up/down counting instead of up only
	localparam int PTB_CTRL_W       = 2;
	localparam int PTB_INT_TRIG_BIT = 0;  // special event trigger happened
	localparam int PTB_INT_WRAP_BIT = 1;  // count reached period

	// reset values
	localparam logic [PTB_CNT_W-1:0]  PTB_COUNT_RST   = 15'h0000;
	localparam logic [PTB_CNT_W-1:0]  PTB_PERIOD_RST  = 15'h0000;
	localparam logic [15:0]           PTB_COMPARE_RST = 16'h0000;
	localparam logic [PTB_CTRL_W-1:0] PTB_CTRL_RST    = 2'h0;
	localparam logic [PTB_INT_W-1:0]  PTB_INT_RST     = 2'h0;
	localparam logic [PTB_DATA_W-1:0] PTB_RDATA_RST   = 32'h0000_0000;

	// bus answer timing: waitrequest stays high this many cycles per request
	localparam int PTB_BUS_WAIT = 1;

	// avalon slave phases, one bit so the path is gray by nature
	typedef enum logic [0:0] {
		PTB_BUS_IDLE = 1'b0,
		PTB_BUS_ACK  = 1'b1
	} ptb_bus_state_type;
endpackage : ptb_pkg

// [hdl/ptb_counter.sv]
// pwm time base counter: up only or up/down, software loadable
module ptb_counter #(
	parameter int W = 15
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	input  wire logic         run,
	input  wire logic         updown,
	input  wire logic [W-1:0] period,
	// state
	output logic      [W-1:0] count,
	output logic              dir,
	output logic              wrap
);
	logic [W-1:0] count_reg;  // current count
	logic         dir_reg;    // one while counting down
	logic         wrap_reg;   // period reached pulse
	logic         at_top;     // count at or past period
	logic         at_zero;    // count at zero

	assign at_top  = (count_reg >= period);
	assign at_zero = (count_reg == '0);

	// count value; a software load wins over counting
	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg <= '0;
		end else if (load) begin
			count_reg <= load_value;
		end else if (run) begin
			if (!updown || !dir_reg) begin
				// up only wraps to zero, up/down turns round at the top
				if (!at_top) count_reg <= count_reg + W'(1);
				else if (!updown || at_zero) count_reg <= '0;
				else count_reg <= count_reg - W'(1);
			end else if (!at_zero) begin
				count_reg <= count_reg - W'(1);
			end else if (period != '0) begin
				count_reg <= W'(1);
			end
		end
	end

	// direction only moves while running; software cannot write it
	always_ff @(posedge clock) begin
		if (rst) begin
			dir_reg <= 1'b0;
		end else if (run) begin
			if (!updown) dir_reg <= 1'b0;
			else if (!dir_reg && at_top && !at_zero) dir_reg <= 1'b1;
			else if (dir_reg && at_zero && period != '0) dir_reg <= 1'b0;
		end
	end

	// one pulse each time the count meets the period going up
	always_ff @(posedge clock) begin
		if (rst) wrap_reg <= 1'b0;
		else wrap_reg <= run && !load && !dir_reg && at_top;
	end

	assign count = count_reg;
	assign dir   = dir_reg;
	assign wrap  = wrap_reg;
endmodule : ptb_counter

// [hdl/ptb_event_cmp.sv]
// special event compare: count and direction against programmed values
module ptb_event_cmp #(
	parameter int W = 15
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// time base
	input  wire logic [W-1:0] count,
	input  wire logic         dir,
	// programmed compare
	input  wire logic [W-1:0] cmp_value,
	input  wire logic         dir_sel,
	// trigger
	output logic              trigger
);
	logic match;        // compare holds this cycle
	logic match_reg;    // compare held last cycle
	logic trigger_reg;  // single-cycle trigger

	// both the value and the direction must agree
	assign match = (count == cmp_value) && (dir == dir_sel);

	// remember the compare so a stalled count fires only once
	// count, direction and compare all clear to zero, so the compare holds out of reset;
	// starting high keeps that from passing for a fresh match
	always_ff @(posedge clock) begin
		if (rst) match_reg <= 1'b1;
		else match_reg <= match;
	end

	// rising edge of the compare gives one pulse
	always_ff @(posedge clock) begin
		if (rst) trigger_reg <= 1'b0;
		else trigger_reg <= match && !match_reg;
	end

	assign trigger = trigger_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_match_rise;
		!match ##1 match;
	endsequence

	chk_trig_cause: assert property (
		trigger |-> $past(count == cmp_value))
		else $error("trigger without count match");
	chk_trig_direction: assert property (
		trigger |-> $past(dir == dir_sel))
		else $error("trigger with wrong direction");
	chk_trig_fires: assert property (
		s_match_rise |=> trigger)
		else $error("match did not trigger");
	chk_trig_single: assert property (
		trigger |=> !trigger)
		else $error("trigger longer than one cycle");
endmodule : ptb_event_cmp

// [hdl/ptb_top.sv]
// Functional notes
// - direction flag reads in count bit 15, read-only
// - count in bits 14-0, read/write, zero at reset
// - period in bits 14-0, writable, zero at reset
// - period bit 15 reads zero, writes ignored
// - trigger only when direction matches selected direction
// - trigger when compare value equals time base count
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
module ptb_top (
	// clock and reset
	input  wire logic                              clock,
	input  wire logic                              rst,
	// avalon-mm slave
	input  wire logic [ptb_pkg::PTB_ADDR_W-1:0]    avs_address,
	input  wire logic [ptb_pkg::PTB_BE_W-1:0]      avs_byteenable,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [ptb_pkg::PTB_DATA_W-1:0]    avs_writedata,
	output logic      [ptb_pkg::PTB_DATA_W-1:0]    avs_readdata,
	output logic                                   avs_waitrequest,
	// time base toward the duty generators
	output logic      [ptb_pkg::PTB_CNT_W-1:0]     time_base_count_value,
	output logic                                   count_direction_flag,
	output logic      [ptb_pkg::PTB_CNT_W-1:0]     period_value,
	// events
	output logic                                   special_event_trigger,
	output logic                                   period_wrap,
	output logic                                   irq
);
	import ptb_pkg::*;

	// address hit on one register word
	function automatic logic ptb_hit(
		input logic [PTB_ADDR_W-1:0] addr,
		input logic [PTB_ADDR_W-1:0] ofs
	);
		ptb_hit = (addr[PTB_ADDR_W-1:2] == ofs[PTB_ADDR_W-1:2]);
	endfunction : ptb_hit

	// merge the two low byte lanes of a write into a 16-bit register
	function automatic logic [15:0] ptb_merge(
		input logic [15:0]           old_value,
		input logic [PTB_DATA_W-1:0] wdata,
		input logic [PTB_BE_W-1:0]   be
	);
		logic [15:0] res;
		res = old_value;
		for (int i = 0; i < 2; i++) begin
			if (be[i]) res[i*8 +: 8] = wdata[i*8 +: 8];
		end
		ptb_merge = res;
	endfunction : ptb_merge

	// bus phase
	ptb_bus_state_type           bus_state_reg;  // idle or answering
	ptb_bus_state_type           bus_state_next;
	logic                        bus_req;        // read or write asked
	logic                        wr_acc;         // write taken this edge
	logic                        rd_acc;         // read taken this edge
	logic [PTB_DATA_W-1:0]       rdata_reg;      // read data, held for the answer
	logic [PTB_DATA_W-1:0]       rdata_next;

	// software registers
	logic [PTB_CNT_W-1:0]        period_reg;     // period value
	logic [15:0]                 compare_reg;    // direction select and compare value
	logic [PTB_CTRL_W-1:0]       ctrl_reg;       // run and up/down mode
	logic [PTB_INT_W-1:0]        status_reg;     // sticky events
	logic [PTB_INT_W-1:0]        mask_reg;       // interrupt enables
	logic                        irq_reg;        // registered interrupt level

	// time base state from the counter
	logic [PTB_CNT_W-1:0]        count;
	logic                        dir;
	logic                        wrap;
	logic                        trigger;
	logic                        count_load;     // software writes the count
	logic [15:0]                 count_merged;   // count word after byte merge
	logic [15:0]                 period_merged;  // period word after byte merge
	logic [PTB_INT_W-1:0]        events;         // this cycle's interrupt sources
	logic [PTB_INT_W-1:0]        status_clr;     // bits cleared by a status read

	// a request is answered on the second cycle; the first cycle lets the
	// read data settle into a register so readdata never comes from logic
	assign bus_req = avs_read || avs_write;
	assign wr_acc  = avs_write && (bus_state_reg == PTB_BUS_ACK);
	assign rd_acc  = avs_read && (bus_state_reg == PTB_BUS_ACK);
	assign avs_waitrequest = bus_req && (bus_state_reg == PTB_BUS_IDLE);

	// bus phase sequencing
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			PTB_BUS_IDLE: begin
				// a new request waits one cycle
				if (bus_req) bus_state_next = PTB_BUS_ACK;
			end
			PTB_BUS_ACK: begin
				// the request ends at this edge
				bus_state_next = PTB_BUS_IDLE;
			end
			default: begin
				bus_state_next = PTB_BUS_IDLE;
			end
		endcase
	end

	// bus phase register
	always_ff @(posedge clock) begin
		if (rst) bus_state_reg <= PTB_BUS_IDLE;
		else bus_state_reg <= bus_state_next;
	end

	// read data selection; unmapped words read as zero
	always_comb begin
		rdata_next = '0;
		if (ptb_hit(avs_address, PTB_OFS_COUNT)) begin
			rdata_next[PTB_DIR_BIT]      = dir;
			rdata_next[PTB_CNT_W-1:0]    = count;
		end else if (ptb_hit(avs_address, PTB_OFS_PERIOD)) begin
			// top bit of the period stays zero
			rdata_next[PTB_CNT_W-1:0]    = period_reg;
		end else if (ptb_hit(avs_address, PTB_OFS_COMPARE)) begin
			rdata_next[15:0]             = compare_reg;
		end else if (ptb_hit(avs_address, PTB_OFS_CONTROL)) begin
			rdata_next[PTB_CTRL_W-1:0]   = ctrl_reg;
		end else if (ptb_hit(avs_address, PTB_OFS_STATUS)) begin
			rdata_next[PTB_INT_W-1:0]    = status_reg;
		end else if (ptb_hit(avs_address, PTB_OFS_MASK)) begin
			rdata_next[PTB_INT_W-1:0]    = mask_reg;
		end
	end

	// capture read data in the waiting cycle only
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_reg <= PTB_RDATA_RST;
		end else if (avs_read && bus_state_reg == PTB_BUS_IDLE) begin
			rdata_reg <= rdata_next;
		end
	end

	// readdata comes straight from the register, never from the decode
	assign avs_readdata = rdata_reg;

	// count writes go straight into the counter; bit 15 is dropped
	// a write during a run lands the new value and counting goes on from it
	assign count_merged = ptb_merge({dir, count}, avs_writedata, avs_byteenable);
	assign count_load   = wr_acc && ptb_hit(avs_address, PTB_OFS_COUNT);

	// period writes merge onto a zero top bit, which is then dropped
	assign period_merged = ptb_merge({1'b0, period_reg}, avs_writedata, avs_byteenable);

	// period register, low fifteen bits only
	// no shadow copy: a new period acts on the very next count compare
	always_ff @(posedge clock) begin
		if (rst) begin
			period_reg <= PTB_PERIOD_RST;
		end else if (wr_acc && ptb_hit(avs_address, PTB_OFS_PERIOD)) begin
			// the top write bit has nowhere to go
			period_reg <= period_merged[PTB_CNT_W-1:0];
		end
	end

	// compare register with its direction select
	// no shadow copy either: a write mid-lap can move the trigger point
	always_ff @(posedge clock) begin
		if (rst) begin
			compare_reg <= PTB_COMPARE_RST;
		end else if (wr_acc && ptb_hit(avs_address, PTB_OFS_COMPARE)) begin
			compare_reg <= ptb_merge(compare_reg, avs_writedata, avs_byteenable);
		end
	end

	// control register, low byte lane
	// lanes above the first are ignored; the run bit is the only gate
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_reg <= PTB_CTRL_RST;
		end else if (wr_acc && ptb_hit(avs_address, PTB_OFS_CONTROL)
			&& avs_byteenable[0]) begin
			ctrl_reg <= avs_writedata[PTB_CTRL_W-1:0];
		end
	end

	// mask register, low byte lane
	// a mask change reaches the pin one cycle later through the irq flop
	always_ff @(posedge clock) begin
		if (rst) begin
			mask_reg <= PTB_INT_RST;
		end else if (wr_acc && ptb_hit(avs_address, PTB_OFS_MASK)
			&& avs_byteenable[0]) begin
			mask_reg <= avs_writedata[PTB_INT_W-1:0];
		end
	end

	// time base counter
	// one count per clock; there is no prescaler in this block
	ptb_counter #(
		.W          (PTB_CNT_W)
	) u_counter (
		.clock      (clock),
		.rst        (rst),
		.load       (count_load),
		.load_value (count_merged[PTB_CNT_W-1:0]),
		.run        (ctrl_reg[PTB_CTRL_RUN_BIT]),
		.updown     (ctrl_reg[PTB_CTRL_UPDN_BIT]),
		.period     (period_reg),
		.count      (count),
		.dir        (dir),
		.wrap       (wrap)
	);

	// special event compare
	// it watches the same count that the bus reads back
	ptb_event_cmp #(
		.W          (PTB_CNT_W)
	) u_event_cmp (
		.clock      (clock),
		.rst        (rst),
		.count      (count),
		.dir        (dir),
		.cmp_value  (compare_reg[PTB_CNT_W-1:0]),
		.dir_sel    (compare_reg[PTB_SEL_BIT]),
		.trigger    (trigger)
	);

	// event sources in status bit order
	assign events[PTB_INT_TRIG_BIT] = trigger;
	assign events[PTB_INT_WRAP_BIT] = wrap;

	// a status read clears only the bits it actually returned, so an
	// event landing between capture and answer is not thrown away
	assign status_clr = (rd_acc && ptb_hit(avs_address, PTB_OFS_STATUS))
		? rdata_reg[PTB_INT_W-1:0] : '0;

	// sticky status bits; a new event wins over the clear
	// one flop per source so clearing one bit leaves the other alone
	generate
		for (genvar g = 0; g < PTB_INT_W; g++) begin : g_status
			always_ff @(posedge clock) begin
				if (rst) status_reg[g] <= 1'b0;
				else if (events[g]) status_reg[g] <= 1'b1;
				else if (status_clr[g]) status_reg[g] <= 1'b0;
			end
		end
	endgenerate

	// interrupt level, registered to keep the pin glitch free
	// the level trails the status by one clock, a cost of the flop
	always_ff @(posedge clock) begin
		if (rst) irq_reg <= 1'b0;
		else irq_reg <= |(status_reg & mask_reg);
	end

	// outputs toward the rest of the pwm
	assign time_base_count_value = count;
	assign count_direction_flag  = dir;
	assign period_value          = period_reg;
	assign special_event_trigger = trigger;
	assign period_wrap           = wrap;
	assign irq                   = irq_reg;

	// checks on the register side
	// all of them run on the one clock and sleep while reset is high,
	// so a single default clocking and disable serve the whole module
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_count_read;
		rd_acc && ptb_hit(avs_address, PTB_OFS_COUNT);
	endsequence

	sequence s_count_write_full;
		wr_acc && ptb_hit(avs_address, PTB_OFS_COUNT) && (&avs_byteenable[1:0]);
	endsequence

	chk_dir_read_back: assert property (
		s_count_read |-> avs_readdata[PTB_DIR_BIT] == $past(dir))
		else $error("count read lost direction flag");
	chk_dir_write_ignored: assert property (
		(s_count_write_full and !ctrl_reg[PTB_CTRL_RUN_BIT]) |=> $stable(dir))
		else $error("write changed direction flag");
	chk_count_load: assert property (
		s_count_write_full |=> count == $past(avs_writedata[PTB_CNT_W-1:0]))
		else $error("count write not taken");
	chk_period_store: assert property (
		(wr_acc && ptb_hit(avs_address, PTB_OFS_PERIOD)
			&& (&avs_byteenable[1:0]))
		|=> period_reg == $past(avs_writedata[PTB_CNT_W-1:0]))
		else $error("period write not taken");
	chk_period_msb: assert property (
		(rd_acc && ptb_hit(avs_address, PTB_OFS_PERIOD))
		|-> avs_readdata[31:PTB_CNT_W] == '0)
		else $error("period top bit not zero");
	chk_bus_answer: assert property (
		(bus_req && avs_waitrequest) |=> !avs_waitrequest)
		else $error("waitrequest held too long");
	chk_irq_level: assert property (
		irq == $past(|(status_reg & mask_reg)))
		else $error("interrupt level wrong");

	// status read as a sequence so the clear checks read like the count ones
	sequence s_status_read;
		rd_acc && ptb_hit(avs_address, PTB_OFS_STATUS);
	endsequence

	sequence s_compare_write_full;
		wr_acc && ptb_hit(avs_address, PTB_OFS_COMPARE) && (&avs_byteenable[1:0]);
	endsequence

	// count bits of a read come from the count seen in the waiting cycle
	chk_count_read_value: assert property (
		s_count_read |-> avs_readdata[PTB_CNT_W-1:0] == $past(count))
		else $error("count read returned wrong value");
	// compare word, direction select included, is stored whole
	chk_compare_store: assert property (
		s_compare_write_full |=> compare_reg == $past(avs_writedata[15:0]))
		else $error("compare write not taken");
	// a stopped time base only moves on a software load
	chk_count_hold: assert property (
		(!ctrl_reg[PTB_CTRL_RUN_BIT] && !count_load) |=> $stable(count))
		else $error("stopped count moved");
	// the direction flag never moves while stopped, whatever is written
	chk_dir_frozen: assert property (
		!ctrl_reg[PTB_CTRL_RUN_BIT] |=> $stable(dir))
		else $error("direction moved while stopped");
	// an event always lands in its sticky bit, even during a clearing read
	chk_status_set: assert property (
		(|events) |=> ((status_reg & $past(events)) == $past(events)))
		else $error("event lost from status");
	// a status read clears what it returned unless the bit fires again
	chk_status_clear: assert property (
		s_status_read |=> ((status_reg & $past(status_clr & ~events)) == '0))
		else $error("status read did not clear");
	// words with no register behind them read as zero
	chk_unmapped_zero: assert property (
		(rd_acc && avs_address[PTB_ADDR_W-1:2] > PTB_OFS_MASK[PTB_ADDR_W-1:2])
		|-> avs_readdata == '0)
		else $error("unmapped word read nonzero");
	// read data only change in a read's waiting cycle
	chk_rdata_hold: assert property (
		!(avs_read && bus_state_reg == PTB_BUS_IDLE) |=> $stable(avs_readdata))
		else $error("read data changed outside a read");
endmodule : ptb_top

// [test/ptb_bench.sv]
// self-checking bench for the pwm time base register block
module pwm_time_base_event_compare_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ptb_pkg::*;

	// clock and reset
	logic                  clock = 1'b0;
	logic                  rst   = 1'b1;
	// avalon master side, idle at time zero
	logic [PTB_ADDR_W-1:0] avs_address    = 5'h00;
	logic [PTB_BE_W-1:0]   avs_byteenable = 4'h0;
	logic                  avs_read       = 1'b0;
	logic                  avs_write      = 1'b0;
	logic [PTB_DATA_W-1:0] avs_writedata  = 32'h0000_0000;
	logic [PTB_DATA_W-1:0] avs_readdata;
	logic                  avs_waitrequest;
	// time base and events
	logic [PTB_CNT_W-1:0]  time_base_count_value;
	logic                  count_direction_flag;
	logic [PTB_CNT_W-1:0]  period_value;
	logic                  special_event_trigger;
	logic                  period_wrap;
	logic                  irq;
	// bookkeeping
	int                    fail_count = 0;
	int                    checked    = 0;
	int                    trig_seen  = 0; // trigger pulses so far
	int                    trig_twice = 0; // trigger high two cycles running
	int                    wrap_seen  = 0; // period wrap pulses so far
	int                    wraps;
	logic                  trig_prev  = 1'b0;
	logic [31:0]           q;
	int                    got;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	ptb_top dut (
		.clock                 (clock),
		.rst                   (rst),
		.avs_address           (avs_address),
		.avs_byteenable        (avs_byteenable),
		.avs_read              (avs_read),
		.avs_write             (avs_write),
		.avs_writedata         (avs_writedata),
		.avs_readdata          (avs_readdata),
		.avs_waitrequest       (avs_waitrequest),
		.time_base_count_value (time_base_count_value),
		.count_direction_flag  (count_direction_flag),
		.period_value          (period_value),
		.special_event_trigger (special_event_trigger),
		.period_wrap           (period_wrap),
		.irq                   (irq)
	);

	// pulse counter; a level trigger would show up as back-to-back highs
	always @(posedge clock) begin
		if (special_event_trigger === 1'b1) begin
			trig_seen <= trig_seen + 1;
		end
		if (trig_prev === 1'b1 && special_event_trigger === 1'b1) begin
			trig_twice <= trig_twice + 1;
		end
		if (period_wrap === 1'b1) begin
			wrap_seen <= wrap_seen + 1;
		end
		trig_prev <= special_event_trigger;
	end

	// verdict and end of run, also reached from a bus timeout
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// one compare, counted
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : check

	// one avalon transfer; request held until waitrequest is sampled low
	task automatic xfer(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
			input logic wr, output logic [31:0] rd);
		int n;
		@(posedge clock);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= ~wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		// bounded wait: a stuck slave ends the run
		if (avs_waitrequest !== 1'b0) begin
			$display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest);
			fail_count++;
			report_and_stop();
		end
	endtask : xfer

	// full-lane write
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] unused;
		xfer(a, d, 4'hF, 1'b1, unused);
	endtask : wr

	// read and compare
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(a, 32'h0000_0000, 4'hF, 1'b0, r);
		check(nm, e, r);
	endtask : rd_chk

	// trigger and period wrap pulses seen over n cycles
	task automatic window(input int n, output int cnt, output int wcnt);
		int s;
		int w;
		s = trig_seen;
		w = wrap_seen;
		repeat (n) @(posedge clock);
		cnt  = trig_seen - s;
		wcnt = wrap_seen - w;
	endtask : window

	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;

		// every register clears at reset
		for (int i = 0; i < 6; i++) begin
			rd_chk("reset value", 5'(i * 4), 32'h0000_0000);
		end
		check("trigger idle", 32'h0, 32'(special_event_trigger));
		$display("test reset done");

		// period keeps 15 bits, top bit reads zero, lanes independent
		wr(PTB_OFS_PERIOD, 32'hFFFF_FFFF);
		rd_chk("period top bit", PTB_OFS_PERIOD, 32'h0000_7FFF);
		check("period port", 32'h0000_7FFF, 32'(period_value));
		wr(PTB_OFS_PERIOD, 32'h0000_1234);
		xfer(PTB_OFS_PERIOD, 32'h0000_56CD, 4'h1, 1'b1, q);
		xfer(PTB_OFS_PERIOD, 32'hFFFF_AB00, 4'h2, 1'b1, q);
		rd_chk("period lanes", PTB_OFS_PERIOD, 32'h0000_2BCD);
		$display("test period done");

		// count loads while stopped; the direction bit ignores writes
		wr(PTB_OFS_COUNT, 32'h0000_8005);
		rd_chk("count load", PTB_OFS_COUNT, 32'h0000_0005);
		check("count port", 32'h5, 32'(time_base_count_value));
		$display("test count done");

		// up-only run, period 20: a down-select never fires
		wr(PTB_OFS_PERIOD, 32'h0000_0014);
		wr(PTB_OFS_COUNT, 32'h0000_0000);
		wr(PTB_OFS_COMPARE, 32'h0000_800A);
		wr(PTB_OFS_CONTROL, 32'h0000_0001);
		window(63, got, wraps);
		check("wrong direction pulses", 32'd0, 32'(got));
		check("wrap pulses up", 32'd2, 32'(wraps));
		wr(PTB_OFS_CONTROL, 32'h0000_0000);
		// up-select fires once per 21-count lap
		wr(PTB_OFS_COUNT, 32'h0000_0000);
		wr(PTB_OFS_COMPARE, 32'h0000_000A);
		rd_chk("compare readback", PTB_OFS_COMPARE, 32'h0000_000A);
		wr(PTB_OFS_CONTROL, 32'h0000_0001);
		window(63, got, wraps);
		check("match pulses", 32'd3, 32'(got));
		check("wrap pulses lap", 32'd2, 32'(wraps));
		wr(PTB_OFS_CONTROL, 32'h0000_0000);
		$display("test compare done");

		// a stalled match fires only once
		wr(PTB_OFS_COUNT, 32'h0000_000A);
		window(20, got, wraps);
		check("stalled match pulses", 32'd1, 32'(got));
		check("stalled wraps", 32'd0, 32'(wraps));
		$display("test stall done");

		// up/down run: down-select fires while the flag says down
		wr(PTB_OFS_COUNT, 32'h0000_0000);
		wr(PTB_OFS_COMPARE, 32'h0000_800A);
		wr(PTB_OFS_CONTROL, 32'h0000_0003);
		got = 0;
		while (special_event_trigger !== 1'b1 && got < 100) begin
			@(posedge clock);
			got++;
		end
		check("down trigger seen", 32'h1, 32'(special_event_trigger));
		check("dir at trigger", 32'h1, 32'(count_direction_flag));
		check("count at trigger", 32'h9, 32'(time_base_count_value));
		wr(PTB_OFS_CONTROL, 32'h0000_0000);
		xfer(PTB_OFS_COUNT, 32'h0, 4'hF, 1'b0, q);
		check("count dir bit", 32'h1, 32'(q[15]));
		wr(PTB_OFS_COUNT, 32'h0000_0000);
		rd_chk("dir survives write", PTB_OFS_COUNT, 32'h0000_8000);
		$display("test updown done");

		// interrupt: masked, unmasked, cleared by status read
		rd_chk("status events", PTB_OFS_STATUS, 32'h0000_0003);
		wr(PTB_OFS_MASK, 32'h0000_0000);
		wr(PTB_OFS_COMPARE, 32'h0000_8005);
		wr(PTB_OFS_COUNT, 32'h0000_0005);
		repeat (4) @(posedge clock);
		check("irq masked", 32'h0, 32'(irq));
		wr(PTB_OFS_MASK, 32'h0000_0001);
		rd_chk("mask readback", PTB_OFS_MASK, 32'h0000_0001);
		repeat (2) @(posedge clock);
		check("irq raised", 32'h1, 32'(irq));
		rd_chk("status sticky", PTB_OFS_STATUS, 32'h0000_0001);
		repeat (3) @(posedge clock);
		check("irq cleared", 32'h0, 32'(irq));
		rd_chk("status clear", PTB_OFS_STATUS, 32'h0000_0000);
		$display("test irq done");

		// unmapped words ignore writes and read zero
		wr(5'h18, 32'hFFFF_FFFF);
		rd_chk("unmapped", 5'h18, 32'h0000_0000);
		check("single-cycle trigger", 32'd0, 32'(trig_twice));
		$display("test unmapped done");
		report_and_stop();
	end
endmodule : pwm_time_base_event_compare_bench
